// ---- pcfg_top.sv ----
// port configuration bits behind a classic Wishbone slave, steering the receive path
// assumes core receive and transmit signals share clk_i; the MAC sits on rmii_rx_o
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "pcfg_consts.svh"

module pcfg_top #(
	parameter logic [`PCFG_CNT_W-1:0] SMALL_LIM = 16'(`PCFG_SMALL_BYTES * `PCFG_DIBITS_PER_BYTE),
	parameter logic [`PCFG_CNT_W-1:0] BIG_LIM   = 16'(`PCFG_BIG_BYTES * `PCFG_DIBITS_PER_BYTE)
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic [`PCFG_ADR_W-1:0]  wb_adr_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic [31:0]                  wb_dat_o,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic                    wb_we_i,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	output logic                         wb_ack_o,
	input  wire pcfg_pkg::pcfg_core_rx_t core_rx_i,
	input  wire pcfg_pkg::pcfg_tx_t      tx_i,
	input  wire logic                    full_duplex_i,
	output pcfg_pkg::pcfg_rmii_rx_t      rmii_rx_o
);
	import pcfg_pkg::*;

	pcfg_cfg_t     cfg_reg;
	logic          ack_reg;
	logic [31:0]   dat_reg;
	logic          ovs_sticky_reg;
	logic          tx_en_d_reg;
	logic          wr_stb;
	logic          rd_stb;
	logic          loop_active;
	logic          oversize;
	pcfg_core_rx_t shaper_in;

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: ack one cycle after the request, writes land at the ack edge
	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
	assign rd_stb = wb_cyc_i && wb_stb_i && !ack_reg;

	function automatic logic [31:0] cfg_word(input pcfg_cfg_t c);
		logic [31:0] w;
		w = 32'h0;
		w[`PCFG_BIT_HEARTBEAT] = c.heartbeat;
		w[`PCFG_BIT_LOOP_DIS]  = c.loop_dis;
		w[`PCFG_BIT_CRS_EXT]   = c.crs_ext;
		w[`PCFG_BIT_FIFO_BIG]  = c.fifo_big;
		w[`PCFG_BIT_PRE_EN]    = c.pre_en;
		return w;
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_reg <= 32'h0;
		else if (rd_stb) begin
			if (wb_adr_i == `PCFG_CFG_ADR)
				dat_reg <= cfg_word(cfg_reg);
			else if (wb_adr_i == `PCFG_STAT_ADR)
				dat_reg <= {28'h0, ovs_sticky_reg, loop_active, rmii_rx_o.dv, rmii_rx_o.crs};
			else
				dat_reg <= 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cfg_reg <= pcfg_cfg_t'(5'((`PCFG_CFG_RST) >> `PCFG_BIT_PRE_EN));
		else if (wr_stb && wb_adr_i == `PCFG_CFG_ADR) begin
			if (wb_sel_i[1]) begin
				cfg_reg.heartbeat <= wb_dat_i[`PCFG_BIT_HEARTBEAT];
				cfg_reg.loop_dis  <= wb_dat_i[`PCFG_BIT_LOOP_DIS];
			end
			if (wb_sel_i[0]) begin
				cfg_reg.crs_ext  <= wb_dat_i[`PCFG_BIT_CRS_EXT];
				cfg_reg.fifo_big <= wb_dat_i[`PCFG_BIT_FIFO_BIG];
				cfg_reg.pre_en   <= wb_dat_i[`PCFG_BIT_PRE_EN];
			end
		end
	end

	// size overrun flag: write one to clear, a new overrun in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ovs_sticky_reg <= 1'b0;
		else if (oversize)
			ovs_sticky_reg <= 1'b1;
		else if (wr_stb && wb_adr_i == `PCFG_STAT_ADR && wb_sel_i[0] && wb_dat_i[`PCFG_ST_OVS])
			ovs_sticky_reg <= 1'b0;
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	////////////////////////////////////////////////////////////////////////////////
	// half duplex transmit loopback into the receive path
	assign loop_active = tx_i.en && !full_duplex_i && !cfg_reg.loop_dis && !core_rx_i.crs;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			tx_en_d_reg <= 1'b0;
		else
			tx_en_d_reg <= tx_i.en;
	end

	always_comb begin
		if (loop_active) begin
			shaper_in.crs   = 1'b1;
			shaper_in.valid = 1'b1;
			shaper_in.sfd   = !tx_en_d_reg;
			shaper_in.dibit = tx_i.txd;
		end else
			shaper_in = core_rx_i;
	end

	pcfg_rx_shaper #(
		.SMALL_LIM (SMALL_LIM),
		.BIG_LIM   (BIG_LIM)
	) u_shaper (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.cfg_i      (cfg_reg),
		.rx_i       (shaper_in),
		.rmii_o     (rmii_rx_o),
		.oversize_o (oversize)
	);

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_loop_block;
		cfg_reg.loop_dis && !core_rx_i.crs && tx_i.en |-> !loop_active && shaper_in == core_rx_i;
	endproperty
	a_loop_block: assert property (p_loop_block) else $error("loopback while disabled");

	property p_hb_stored;
		wr_stb && wb_adr_i == 8'h10 && wb_sel_i[1] |=> cfg_reg.heartbeat == $past(wb_dat_i[9]);
	endproperty
	a_hb_stored: assert property (p_hb_stored) else $error("heartbeat write lost");

	property p_ack_pulse;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack timing wrong");

	property p_ack_needs_req;
		wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
	endproperty
	a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");

	property p_ovs_set_wins;
		oversize |=> ovs_sticky_reg;
	endproperty
	a_ovs_set_wins: assert property (p_ovs_set_wins) else $error("size overrun flag not set");

	property p_ovs_clear;
		wr_stb && wb_adr_i == `PCFG_STAT_ADR && wb_sel_i[0] && wb_dat_i[`PCFG_ST_OVS] && !oversize
			|=> !ovs_sticky_reg;
	endproperty
	a_ovs_clear: assert property (p_ovs_clear) else $error("size overrun flag not cleared");

	property p_rsvd_read_zero;
		rd_stb && wb_adr_i == `PCFG_CFG_ADR |=> (wb_dat_o & 32'hffff_fc1f) == 32'h0;
	endproperty
	a_rsvd_read_zero: assert property (p_rsvd_read_zero) else $error("reserved config bits not zero");

	property p_unmapped_zero;
		rd_stb && wb_adr_i != `PCFG_CFG_ADR && wb_adr_i != `PCFG_STAT_ADR |=> wb_dat_o == 32'h0;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	property p_sel_hi_keep;
		wr_stb && wb_adr_i == `PCFG_CFG_ADR && !wb_sel_i[1]
			|=> $stable(cfg_reg.heartbeat) && $stable(cfg_reg.loop_dis);
	endproperty
	a_sel_hi_keep: assert property (p_sel_hi_keep) else $error("unselected byte written");

	property p_full_no_loop;
		full_duplex_i && !core_rx_i.crs |-> shaper_in == core_rx_i;
	endproperty
	a_full_no_loop: assert property (p_full_no_loop) else $error("loopback in full duplex");

	c_loopback: cover property (loop_active ##1 rmii_rx_o.dv);
	c_hb_write: cover property (wr_stb && wb_adr_i == 8'h10 && wb_dat_i[9]);
endmodule

// ---- pcfg_consts.svh ----
// offsets, field positions, reset values and counts of the port configuration block
// assumes a 10 MHz core clock and one receive dibit per clock
//
// Overview of operation
// - heartbeat bit is writable and readable but steers nothing
// - loopback-disable at 1 stops half duplex transmit loopback into receive
// - carrier-sense select at 1 holds carrier sense until receive data valid drops
// - FIFO size 0 limits packets to 2 KBytes, 1 to 10 KBytes
// - limits hold with up to 450 ppm between reference and recovered clock
// - preamble enable 0: valid rises at SFD; 1: valid and preamble on carrier
`ifndef PCFG_CONSTS_SVH
`define PCFG_CONSTS_SVH

`define PCFG_ADR_W           8
`define PCFG_CFG_ADR         8'h10
`define PCFG_STAT_ADR        8'h14

`define PCFG_BIT_HEARTBEAT   9
`define PCFG_BIT_LOOP_DIS    8
`define PCFG_BIT_CRS_EXT     7
`define PCFG_BIT_FIFO_BIG    6
`define PCFG_BIT_PRE_EN      5
`define PCFG_CFG_RST         32'h0000_0180

`define PCFG_ST_CRS          0
`define PCFG_ST_DV           1
`define PCFG_ST_LOOP         2
`define PCFG_ST_OVS          3

`define PCFG_PRE_DIBIT       2'h1
`define PCFG_SMALL_BYTES     2048
`define PCFG_BIG_BYTES       10240
`define PCFG_DIBITS_PER_BYTE 4
`define PCFG_PPM             450
`define PCFG_CNT_W           16

`endif

// ---- pcfg_pkg.sv ----
// types shared by the port configuration block
// assumes pcfg_consts.svh is on the include path
`include "pcfg_consts.svh"

package pcfg_pkg;

	typedef struct packed {
		logic heartbeat;
		logic loop_dis;
		logic crs_ext;
		logic fifo_big;
		logic pre_en;
	} pcfg_cfg_t;

	typedef struct packed {
		logic       crs;
		logic       valid;
		logic       sfd;
		logic [1:0] dibit;
	} pcfg_core_rx_t;

	typedef struct packed {
		logic       en;
		logic [1:0] txd;
	} pcfg_tx_t;

	typedef struct packed {
		logic       crs;
		logic       dv;
		logic [1:0] rxd;
	} pcfg_rmii_rx_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_SFD,
		ST_PRE,
		ST_DATA,
		ST_DROP
	} pcfg_rx_state_t;

endpackage

// ---- pcfg_rx_shaper.sv ----
// receive side shaping toward the reduced MII: valid, preamble, carrier and size limit
// assumes receive symbols arrive from core logic on the same clock
`timescale 1ns/1ns
`include "pcfg_consts.svh"

module pcfg_rx_shaper #(
	parameter logic [`PCFG_CNT_W-1:0] SMALL_LIM = 16'd8192,
	parameter logic [`PCFG_CNT_W-1:0] BIG_LIM   = 16'd40960
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire pcfg_pkg::pcfg_cfg_t    cfg_i,
	input  wire pcfg_pkg::pcfg_core_rx_t rx_i,
	output pcfg_pkg::pcfg_rmii_rx_t     rmii_o,
	output logic                        oversize_o
);
	import pcfg_pkg::*;

	pcfg_rx_state_t          state_reg;
	pcfg_rx_state_t          state_next;
	logic [`PCFG_CNT_W-1:0] cnt_reg;
	logic [`PCFG_CNT_W-1:0] lim;
	pcfg_rmii_rx_t          out_reg;
	logic                   ovs_reg;
	logic                   dv_next;

	assign lim = cfg_i.fifo_big ? BIG_LIM : SMALL_LIM;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (rx_i.crs) begin
					if (rx_i.sfd)
						state_next = ST_DATA;
					else if (cfg_i.pre_en)
						state_next = ST_PRE;
					else
						state_next = ST_WAIT_SFD;
				end
			end
			ST_WAIT_SFD, ST_PRE: begin
				if (rx_i.sfd)
					state_next = ST_DATA;
				else if (!rx_i.crs)
					state_next = ST_IDLE;
			end
			ST_DATA: begin
				if (!rx_i.valid)
					state_next = ST_IDLE;
				else if (cnt_reg >= lim - 16'd1)
					state_next = ST_DROP;
			end
			ST_DROP: begin
				if (!rx_i.valid && !rx_i.crs)
					state_next = ST_IDLE;
			end
		endcase
	end

	assign dv_next = (state_next == ST_PRE) || (state_next == ST_DATA);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// dibits are counted on the local clock, so up to 450 ppm of drift only moves fill
	always_ff @(posedge clk_i) begin
		if (rst_i || state_next != ST_DATA)
			cnt_reg <= '0;
		else if (state_reg == ST_DATA)
			cnt_reg <= cnt_reg + 16'd1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_reg <= '0;
			ovs_reg <= 1'b0;
		end else begin
			out_reg.dv  <= dv_next;
			out_reg.crs <= rx_i.crs || (cfg_i.crs_ext && dv_next);
			if (state_next == ST_PRE)
				out_reg.rxd <= `PCFG_PRE_DIBIT;
			else if (state_next == ST_DATA)
				out_reg.rxd <= rx_i.dibit;
			else
				out_reg.rxd <= 2'h0;
			ovs_reg <= (state_reg == ST_DATA) && (state_next == ST_DROP);
		end
	end

	assign rmii_o     = out_reg;
	assign oversize_o = ovs_reg;

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_dv_at_sfd;
		$rose(rmii_o.dv) && !$past(cfg_i.pre_en) |-> $past(rx_i.sfd);
	endproperty
	a_dv_at_sfd: assert property (p_dv_at_sfd) else $error("valid rose without sfd");

	property p_pre_on_crs;
		state_reg == ST_IDLE && rx_i.crs && !rx_i.sfd && cfg_i.pre_en |=> rmii_o.dv && rmii_o.rxd == 2'h1;
	endproperty
	a_pre_on_crs: assert property (p_pre_on_crs) else $error("no preamble on carrier");

	property p_crs_hold;
		$past(cfg_i.crs_ext) && rmii_o.dv |-> rmii_o.crs;
	endproperty
	a_crs_hold: assert property (p_crs_hold) else $error("carrier dropped before valid");

	property p_crs_normal;
		!$past(cfg_i.crs_ext) |-> rmii_o.crs == $past(rx_i.crs);
	endproperty
	a_crs_normal: assert property (p_crs_normal) else $error("carrier not following line");

	property p_size_cut;
		oversize_o |-> !rmii_o.dv ##1 !rmii_o.dv;
	endproperty
	a_size_cut: assert property (p_size_cut) else $error("valid after size limit");

	property p_count_bound;
		state_reg == ST_DATA && $stable(cfg_i.fifo_big) |-> cnt_reg < lim;
	endproperty
	a_count_bound: assert property (p_count_bound) else $error("count past limit");

	c_preamble: cover property (state_reg == ST_PRE ##1 state_reg == ST_DATA);
	c_oversize: cover property (oversize_o);
	c_crs_ext:  cover property (cfg_i.crs_ext && rmii_o.dv && !rx_i.crs);
endmodule

// ---- pcfg_mac_model.sv ----
// mac model on the far side of the reduced mii: sends transmit bursts, counts what it receives
// assumes tx_o and rmii_i share clk_i with the design
`timescale 1ns/1ns

module pcfg_mac_model (
	input  wire logic                    clk_i,
	input  wire logic                    clr_i,
	input  wire logic [7:0]              send_i,
	input  wire pcfg_pkg::pcfg_rmii_rx_t rmii_i,
	output pcfg_pkg::pcfg_tx_t           tx_o,
	output logic [7:0]                   dv_cnt_o,
	output logic [7:0]                   crs_cnt_o,
	output logic [1:0]                   first_rxd_o
);
	import pcfg_pkg::*;
	logic [7:0] left_reg = 8'h0;
	logic       tog_reg  = 1'b0;
	logic       dv_prev;

	////////////////////////////////////////////////////////////////////////////////
	// transmit burst of send_i cycles; idle data lines toggle so no stale value shows
	always_ff @(posedge clk_i) begin
		tog_reg <= ~tog_reg;
		if (clr_i || left_reg != 8'h0) begin
			left_reg <= clr_i ? 8'h0 : left_reg - 8'h1;
		end else begin
			left_reg <= send_i;
		end
	end
	assign tx_o.en  = (left_reg != 8'h0);
	assign tx_o.txd = tx_o.en ? left_reg[1:0] : {tog_reg, ~tog_reg};

	////////////////////////////////////////////////////////////////////////////////
	// receive counters
	always_ff @(posedge clk_i) begin
		if (clr_i) begin
			dv_cnt_o  <= 8'h0;
			crs_cnt_o <= 8'h0;
		end else begin
			dv_cnt_o  <= dv_cnt_o + 8'(rmii_i.dv);
			crs_cnt_o <= crs_cnt_o + 8'(rmii_i.crs);
		end
		if (rmii_i.dv && !dv_prev) begin
			first_rxd_o <= rmii_i.rxd;
		end
		dv_prev <= rmii_i.dv;
	end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the port configuration block with a mac model
// assumes small packet limits of 16 and 40 dibits set at the instance
`timescale 1ns/1ns
`include "pcfg_consts.svh"

module tb_top;
	import pcfg_pkg::*;
	logic           clk = 1'b0;
	logic           rst = 1'b1;
	logic [7:0]     adr = 8'h0;
	logic [31:0]    wdat = 32'h0;
	logic [31:0]    rdat;
	logic [31:0]    rd;
	logic [3:0]     sel = 4'h0;
	logic           we = 1'b0;
	logic           cyc = 1'b0;
	logic           ack;
	pcfg_core_rx_t  rx = '0;
	pcfg_tx_t       tx;
	pcfg_rmii_rx_t  rmii;
	logic           fdx = 1'b0;
	logic           clr = 1'b0;
	logic [7:0]     send = 8'h0;
	logic [7:0]     dvn;
	logic [7:0]     crsn;
	logic [1:0]     frx;
	int             num_errors = 0;
	int             cmp_count = 0;
	int             seed = 32'hcd8e;

	always #50 clk = ~clk;

	pcfg_top #(.SMALL_LIM(16'd16), .BIG_LIM(16'd40)) pcfg_top_i (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_ack_o(ack), .core_rx_i(rx), .tx_i(tx), .full_duplex_i(fdx), .rmii_rx_o(rmii));
	pcfg_mac_model pcfg_mac_model_i (.clk_i(clk), .clr_i(clr), .send_i(send), .rmii_i(rmii), .tx_o(tx),
		.dv_cnt_o(dvn), .crs_cnt_o(crsn), .first_rxd_o(frx));

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic chk_n(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("Error at %0t: count %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
		int n;
		adr <= a;
		wdat <= d;
		we <= w;
		sel <= 4'hf;
		cyc <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			conclude();
		end
		q = rdat;
		cyc <= 1'b0;
		@(posedge clk);
	endtask

	task automatic setcfg(input logic [4:0] c);
		wb(8'h10, {22'h0, c, 5'h0}, 1'b1, rd);
	endtask

	task automatic frame(input int p, input int len);
		for (int i = 0; i < p + len; i++) begin
			clr <= (i == 0);
			rx <= '{crs: (i < p + len - 2), valid: (i >= p), sfd: (i == p),
				dibit: (i < p) ? 2'h1 : (i == p) ? 2'h3 : 2'($random(seed))};
			@(posedge clk);
		end
		clr <= 1'b0;
		rx <= '{crs: 1'b0, valid: 1'b0, sfd: 1'b0, dibit: 2'($random(seed))};
		repeat (4) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [4:0] c;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wb(8'h10, 32'h0, 1'b0, rd);
		chk_d(rd, 32'h180);
		wb(8'h20, 32'h0, 1'b0, rd);
		chk_d(rd, 32'h0);
		wb(8'h14, 32'h0, 1'b0, rd);
		chk_d(rd, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			c = 5'($random(seed));
			setcfg(c);
			wb(8'h10, 32'h0, 1'b0, rd);
			chk_d(rd, {22'h0, c, 5'h0});
		end
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			setcfg({i[2], 1'b1, i[1], 1'b0, i[0]});
			frame(4, 10);
			chk_n(dvn, i[0] ? 8'd14 : 8'd10);
			chk_n(crsn, i[1] ? 8'd14 : 8'd12);
			chk_n({6'h0, frx}, i[0] ? 8'h1 : 8'h3);
		end
		$display("test framing done");
		for (int i = 0; i < 2; i++) begin
			setcfg({3'b010, i[0], 1'b0});
			frame(4, 30);
			chk_n(dvn, i[0] ? 8'd30 : 8'd16);
			wb(8'h14, 32'h0, 1'b0, rd);
			chk_d(rd, i[0] ? 32'h0 : 32'h8);
			wb(8'h14, 32'h8, 1'b1, rd);
			wb(8'h14, 32'h0, 1'b0, rd);
			chk_d(rd, 32'h0);
		end
		$display("test size limit done");
		for (int i = 0; i < 3; i++) begin
			fdx <= (i == 2);
			setcfg({1'b0, i == 1, 3'h0});
			clr <= 1'b1;
			@(posedge clk);
			clr <= 1'b0;
			send <= 8'd12;
			@(posedge clk);
			send <= 8'h0;
			repeat (20) @(posedge clk);
			chk_n(dvn, (i == 0) ? 8'd12 : 8'd0);
			chk_n(crsn, (i == 0) ? 8'd12 : 8'd0);
		end
		$display("test loopback done");
		conclude();
	end
endmodule
